// ### pkg/sdram_link_cfg.svh
// Purpose: shared timing counts and field positions of the sdram pin link
// Assumes: system clock of 50 ns on both ends
// Notes: link clock period is a whole multiple of four system clocks
`ifndef SDRAM_LINK_CFG_SVH
`define SDRAM_LINK_CFG_SVH
`define CLK_PERIOD_NS 50
`define LINK_PERIOD_NS 400
`define LINK_DIV (`LINK_PERIOD_NS / `CLK_PERIOD_NS)
`define ADDR_W 14
`define BANKS 4
`define AUTO_PRE_BIT 10
// over-temperature limit, 85 degrees celsius
`define TEMP_LIMIT_C 8'sh55
`define RD_WAIT_PERIODS 2'h3
`endif

// ### pkg/sdram_link_if.sv
// Purpose: pin bundle between memory device and controller
// Assumes: undriven data and strobe wires read as zero
// Notes: two-way pins resolved here from both output enables
`timescale 1ns/1ps
`include "sdram_link_cfg.svh"
interface sdram_link_if #(parameter int DQ_W = 16) ();
  localparam int LANES = DQ_W / 8;
  logic ck;
  logic cs_n;
  logic ras_n;
  logic cas_n;
  logic we_n;
  logic bank_select_lsb;
  logic bank_select_msb;
  logic [`ADDR_W-1:0] addr;
  logic [LANES-1:0] dm;
  logic [DQ_W-1:0] ctl_dq_o;
  logic ctl_dq_oe;
  logic [LANES-1:0] ctl_dqs_o;
  logic ctl_dqs_oe;
  logic [DQ_W-1:0] dev_dq_o;
  logic dev_dq_oe;
  logic [LANES-1:0] dev_dqs_o;
  logic dev_dqs_oe;
  logic [DQ_W-1:0] dq;
  logic [LANES-1:0] dqs;
  logic over_temperature_flag;
  assign dq = dev_dq_oe ? dev_dq_o : (ctl_dq_oe ? ctl_dq_o : '0);
  assign dqs = dev_dqs_oe ? dev_dqs_o : (ctl_dqs_oe ? ctl_dqs_o : '0);
  modport dev (
    input ck, cs_n, ras_n, cas_n, we_n, bank_select_lsb, bank_select_msb, addr, dm, dq, dqs,
    output dev_dq_o, dev_dq_oe, dev_dqs_o, dev_dqs_oe, over_temperature_flag
  );
  modport ctl (
    output ck, cs_n, ras_n, cas_n, we_n, bank_select_lsb, bank_select_msb, addr, dm,
    output ctl_dq_o, ctl_dq_oe, ctl_dqs_o, ctl_dqs_oe,
    input dq, dqs, over_temperature_flag
  );
endinterface : sdram_link_if

// ### pkg/sdram_pkg.sv
// Purpose: types shared by both ends of the sdram pin link
// Assumes: command code is {ras_n, cas_n, we_n} with chip select low
// Notes: none
package sdram_pkg;
  typedef enum logic [2:0] {
    CMD_LMR = 3'h0,
    CMD_PRE = 3'h2,
    CMD_ACT = 3'h3,
    CMD_WRITE = 3'h4,
    CMD_READ = 3'h5,
    CMD_NOP = 3'h7
  } cmd_t;
  typedef enum logic [2:0] {
    D_IDLE = 3'h0,
    D_RD_PRE = 3'h1,
    D_RD_B0 = 3'h3,
    D_RD_B1 = 3'h2,
    D_RD_END = 3'h6,
    D_WR = 3'h4
  } dev_state_t;
  typedef enum logic [1:0] {
    C_IDLE = 2'h0,
    C_CMD = 2'h1,
    C_WR = 2'h3,
    C_RD = 2'h2
  } ctl_state_t;
endpackage : sdram_pkg

// ### test/sdram_link_monitor.sv
// Purpose: pin-level checks on the link between device and controller ends
// Assumes: divider of 8 system clocks per link period
// Notes: sees interface signals only
`timescale 1ns/1ps
`include "sdram_link_cfg.svh"
module sdram_link_monitor #(
  parameter int DQ_W = 16
) (
  // system
  input logic clk,
  input logic reset_n,
  // command pins
  input logic ck,
  input logic cs_n,
  input logic ras_n,
  input logic cas_n,
  input logic we_n,
  input logic bank_select_lsb,
  input logic bank_select_msb,
  input logic [`ADDR_W-1:0] addr,
  // data pins
  input logic [DQ_W/8-1:0] dm,
  input logic [DQ_W-1:0] dq,
  input logic [DQ_W/8-1:0] dqs,
  input logic ctl_dq_oe,
  input logic ctl_dqs_oe,
  input logic dev_dq_oe,
  input logic dev_dqs_oe
);
  logic [`ADDR_W+5:0] pins;
  assign pins = {cs_n, ras_n, cas_n, we_n, bank_select_msb, bank_select_lsb, addr};
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  a_cmd_hold_high: assert property (ck |-> $stable(pins))
    else $error("command pins moved while link clock high");
  a_ck_half_period: assert property ($rose(ck) |-> ck[*4] ##1 !ck[*4])
    else $error("link clock high or low time wrong");
  a_cmd_launch_low: assert property ($fell(cs_n) |-> !ck ##4 $rose(ck))
    else $error("command not centred on link clock rise");
  a_cmd_one_period: assert property ($fell(cs_n) |-> !cs_n[*8] ##1 cs_n)
    else $error("selected command did not last one link period");
  a_strobe_one_owner: assert property (!(dev_dqs_oe && ctl_dqs_oe))
    else $error("both ends drive the strobe");
  a_data_one_owner: assert property (dev_dq_oe |-> !ctl_dq_oe)
    else $error("both ends drive the data bus");
  a_wr_strobe_centre: assert property (ctl_dqs_oe && $past(ctl_dqs_oe) && dqs != $past(dqs)
    |-> dq == $past(dq))
    else $error("write data moved on a strobe edge");
  a_wr_strobe_shape: assert property ($rose(ctl_dqs_oe) |-> dqs == '0 ##2 dqs == '1
    ##4 dqs == '0 ##2 !ctl_dqs_oe)
    else $error("write strobe timing wrong");
  a_rd_edge_align: assert property (dev_dqs_oe && $past(dev_dqs_oe) && dev_dq_oe
    && $past(dev_dq_oe) && dq != $past(dq) |-> dqs != $past(dqs))
    else $error("read data moved without a strobe edge");
  a_mask_in_write: assert property (dm != '0 |-> ctl_dq_oe)
    else $error("mask raised outside write data");
endmodule : sdram_link_monitor

// ### test/tb_sdram_addr_strobe_pin_decode.sv
// Purpose: bench joining controller end and device end over the pin link
// Assumes: 16-bit data, divider of 8
// Notes: requests go in at the controller, results read at both user sides
`timescale 1ns/1ps
`include "sdram_link_cfg.svh"
module tb_sdram_addr_strobe_pin_decode;
  logic clk;
  logic reset_n;
  logic req_valid;
  logic req_ready;
  sdram_pkg::cmd_t req_cmd;
  logic [1:0] req_bank;
  logic [`ADDR_W-1:0] req_addr;
  logic [31:0] req_wdata;
  logic [3:0] req_wmask;
  logic [31:0] rsp_data;
  logic rsp_valid;
  logic temp_alarm;
  logic signed [7:0] junction_temp_c;
  logic [`ADDR_W-1:0] mode_std;
  logic [`ADDR_W-1:0] mode_ext;
  logic [3:0] bank_open;
  int fail_count;
  int checks;
  sdram_link_if #(.DQ_W(16)) link ();
  sdram_dev #(.DQ_W(16)) i_sdram_dev (.clk(clk), .reset_n(reset_n), .link(link),
    .junction_temp_c(junction_temp_c), .mode_std(mode_std), .mode_ext(mode_ext),
    .bank_open(bank_open));
  sdram_ctl #(.DQ_W(16)) i_sdram_ctl (.clk(clk), .reset_n(reset_n), .link(link),
    .req_valid(req_valid), .req_ready(req_ready), .req_cmd(req_cmd), .req_bank(req_bank),
    .req_addr(req_addr), .req_wdata(req_wdata), .req_wmask(req_wmask),
    .rsp_data(rsp_data), .rsp_valid(rsp_valid), .temp_alarm(temp_alarm));
  sdram_link_monitor #(.DQ_W(16)) i_sdram_link_monitor (.clk(clk), .reset_n(reset_n),
    .ck(link.ck), .cs_n(link.cs_n), .ras_n(link.ras_n), .cas_n(link.cas_n),
    .we_n(link.we_n), .bank_select_lsb(link.bank_select_lsb),
    .bank_select_msb(link.bank_select_msb), .addr(link.addr), .dm(link.dm), .dq(link.dq),
    .dqs(link.dqs), .ctl_dq_oe(link.ctl_dq_oe), .ctl_dqs_oe(link.ctl_dqs_oe),
    .dev_dq_oe(link.dev_dq_oe), .dev_dqs_oe(link.dev_dqs_oe));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task automatic test_done();
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : test_done
  task automatic cmp_val(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : cmp_val
  task automatic cmp_flag(input logic got, input logic exp, input string what);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: %s got %b expected %b", $time, what, got, exp);
    end
  endtask : cmp_flag
  // hold the request from a falling edge until the ready pulse has been taken
  task automatic issue(input sdram_pkg::cmd_t c, input logic [1:0] b,
      input logic [`ADDR_W-1:0] a, input logic [31:0] wd, input logic [3:0] wm);
    int n;
    n = 0;
    @(negedge clk);
    req_cmd = c;
    req_bank = b;
    req_addr = a;
    req_wdata = wd;
    req_wmask = wm;
    req_valid = 1'b1;
    while (req_ready !== 1'b1 && n < 100) begin
      @(negedge clk);
      n++;
    end
    cmp_flag(n < 100, 1'b1, "request accepted");
    @(negedge clk);
    req_valid = 1'b0;
  endtask : issue
  task automatic op(input sdram_pkg::cmd_t c, input logic [1:0] b,
      input logic [`ADDR_W-1:0] a, input logic [31:0] wd, input logic [3:0] wm);
    issue(c, b, a, wd, wm);
    repeat (24) @(negedge clk);
  endtask : op
  task automatic rd(input logic [1:0] b, input logic [`ADDR_W-1:0] a, input logic ans,
      input logic [31:0] exp);
    int n;
    logic seen;
    n = 0;
    seen = 1'b0;
    issue(sdram_pkg::CMD_READ, b, a, 32'h0, 4'h0);
    while (!seen && n < 60) begin
      @(negedge clk);
      n++;
      if (rsp_valid === 1'b1) seen = 1'b1;
    end
    cmp_flag(seen, ans, "read answered");
    if (seen) cmp_val(rsp_data, exp, "read data");
    repeat (8) @(negedge clk);
  endtask : rd
  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    $display("mismatch at %0t: run did not finish", $time);
    test_done();
  end
  initial begin
    logic signed [7:0] temps [3];
    temps = '{8'sh55, 8'sh56, 8'sh19};
    fail_count = 0;
    checks = 0;
    reset_n = 1'b0;
    req_valid = 1'b0;
    req_cmd = sdram_pkg::CMD_NOP;
    req_bank = 2'h0;
    req_addr = '0;
    req_wdata = 32'h0;
    req_wmask = 4'h0;
    junction_temp_c = 8'sh19;
    repeat (5) @(negedge clk);
    reset_n = 1'b1;
    cmp_val(32'($bits(link.dq)), 32'h10, "x16 data bus width");
    cmp_val(32'($bits(link.dqs)), 32'h2, "one strobe per byte lane");
    op(sdram_pkg::CMD_LMR, 2'h0, 14'h0032, 32'h0, 4'h0);
    cmp_val(32'(mode_std), 32'h0032, "standard mode");
    op(sdram_pkg::CMD_LMR, 2'h2, 14'h0021, 32'h0, 4'h0);
    cmp_val(32'(mode_ext), 32'h0021, "extended mode");
    cmp_val(32'(mode_std), 32'h0032, "standard mode kept");
    cmp_val(32'(bank_open), 32'h0, "no bank open");
    rd(2'h1, 14'h0004, 1'b0, 32'h0);
    op(sdram_pkg::CMD_ACT, 2'h1, 14'h0001, 32'h0, 4'h0);
    cmp_val(32'(bank_open), 32'h2, "bank 1 open");
    op(sdram_pkg::CMD_ACT, 2'h3, 14'h0002, 32'h0, 4'h0);
    cmp_val(32'(bank_open), 32'ha, "banks 1 and 3 open");
    cmp_flag(link.cs_n, 1'b1, "deselected between commands");
    op(sdram_pkg::CMD_WRITE, 2'h1, 14'h0004, 32'h5a5a_a5a5, 4'h0);
    op(sdram_pkg::CMD_WRITE, 2'h3, 14'h0004, 32'h1234_5678, 4'h0);
    op(sdram_pkg::CMD_WRITE, 2'h1, 14'h0004, 32'hffff_0000, 4'h6);
    cmp_val(32'(bank_open), 32'ha, "writes keep banks open");
    rd(2'h1, 14'h0004, 1'b1, 32'hff5a_a500);
    rd(2'h3, 14'h0404, 1'b1, 32'h1234_5678);
    cmp_val(32'(bank_open), 32'h2, "auto precharge closed bank 3");
    rd(2'h3, 14'h0004, 1'b0, 32'h0);
    op(sdram_pkg::CMD_ACT, 2'h0, 14'h0003, 32'h0, 4'h0);
    op(sdram_pkg::CMD_PRE, 2'h1, 14'h0000, 32'h0, 4'h0);
    cmp_val(32'(bank_open), 32'h1, "single bank precharge");
    op(sdram_pkg::CMD_ACT, 2'h2, 14'h0000, 32'h0, 4'h0);
    op(sdram_pkg::CMD_PRE, 2'h0, 14'h0400, 32'h0, 4'h0);
    cmp_val(32'(bank_open), 32'h0, "all bank precharge");
    for (int i = 0; i < 3; i++) begin
      junction_temp_c = temps[i];
      repeat (8) @(negedge clk);
      cmp_flag(link.over_temperature_flag, temps[i] > `TEMP_LIMIT_C, "temp flag");
      cmp_flag(temp_alarm, temps[i] > `TEMP_LIMIT_C, "temp alarm");
    end
    test_done();
  end
endmodule : tb_sdram_addr_strobe_pin_decode

// ### verilog/sdram_ctl.sv
// Purpose: controller end: makes link clock, issues commands, moves burst-of-two data
// Assumes: one request per link clock period at most
// Notes: read data is captured on synchronised strobe edges
`timescale 1ns/1ps
`include "sdram_link_cfg.svh"
module sdram_ctl #(
  parameter int DQ_W = 16,
  parameter int DIV = `LINK_DIV
) (
  // system
  input wire logic clk,
  input wire logic reset_n,
  // link
  sdram_link_if.ctl link,
  // request
  input wire logic req_valid,
  output logic req_ready,
  input wire sdram_pkg::cmd_t req_cmd,
  input wire logic [1:0] req_bank,
  input wire logic [`ADDR_W-1:0] req_addr,
  input wire logic [2*DQ_W-1:0] req_wdata,
  input wire logic [2*(DQ_W/8)-1:0] req_wmask,
  // response
  output logic [2*DQ_W-1:0] rsp_data,
  output logic rsp_valid,
  output logic temp_alarm
);
  localparam int LANES = DQ_W / 8;
  localparam int PW = $clog2(DIV);
  localparam logic [PW-1:0] P_HALF = PW'(DIV / 2);
  localparam logic [PW-1:0] P_CMD = PW'(DIV / 2 - 1);
  localparam logic [PW-1:0] P_DQS_LO = PW'(DIV / 4 - 1);
  localparam logic [PW-1:0] P_DQS_HI = PW'(DIV / 2 + DIV / 4 - 1);
  localparam logic [PW-1:0] P_LAST = PW'(DIV - 1);

  typedef struct packed {
    logic flag;
    logic [DQ_W-1:0] dq;
    logic [LANES-1:0] dqs;
  } pins_t;

  typedef struct packed {
    logic [PW-1:0] phase;
    logic ck;
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic [1:0] ba;
    logic [`ADDR_W-1:0] addr;
    logic [LANES-1:0] dm;
    logic [DQ_W-1:0] dq_o;
    logic dq_oe;
    logic [LANES-1:0] dqs_o;
    logic dqs_oe;
    sdram_pkg::ctl_state_t st;
    logic [2*DQ_W-1:0] wbuf;
    logic [2*LANES-1:0] wmask;
    logic [1:0] wait_cnt;
    pins_t s1;
    pins_t s2;
    logic [LANES-1:0] dqs_prev;
    logic [2*DQ_W-1:0] rdata;
    logic rvalid;
    logic alarm;
  } state_t;

  state_t state_q;
  state_t state_d;
  sdram_pkg::cmd_t cmd_q;

  assign req_ready = (state_q.st == sdram_pkg::C_IDLE) && (state_q.phase == P_CMD);
  assign cmd_q = sdram_pkg::cmd_t'({state_q.ras_n, state_q.cas_n, state_q.we_n});

  always_comb begin
    state_d = state_q;
    state_d.phase = (state_q.phase == P_LAST) ? '0 : state_q.phase + PW'(1);
    state_d.ck = state_d.phase < P_HALF;
    state_d.s1 = {link.over_temperature_flag, link.dq, link.dqs};
    state_d.s2 = state_q.s1;
    state_d.dqs_prev = state_q.s2.dqs;
    state_d.alarm = state_q.s2.flag;
    state_d.rvalid = 1'b0;
    case (state_q.st)
      sdram_pkg::C_IDLE: begin
        if (req_valid && req_ready) begin
          // pins change while link clock is low, stable across its rise
          {state_d.ras_n, state_d.cas_n, state_d.we_n} = req_cmd;
          state_d.cs_n = 1'b0;
          {state_d.ba, state_d.addr} = {req_bank, req_addr};
          state_d.wbuf = req_wdata;
          state_d.wmask = req_wmask;
          state_d.st = sdram_pkg::C_CMD;
        end
      end
      sdram_pkg::C_CMD: begin
        if (state_q.phase == P_CMD) begin
          state_d.cs_n = 1'b1;
          {state_d.ras_n, state_d.cas_n, state_d.we_n} = sdram_pkg::CMD_NOP;
          state_d.wait_cnt = '0;
          state_d.st = sdram_pkg::C_IDLE;
          if (cmd_q == sdram_pkg::CMD_WRITE) begin
            state_d.dq_o = state_q.wbuf[DQ_W-1:0];
            state_d.dm = state_q.wmask[LANES-1:0];
            state_d.dq_oe = 1'b1;
            state_d.dqs_oe = 1'b1;
            state_d.dqs_o = '0;
            state_d.st = sdram_pkg::C_WR;
          end else if (cmd_q == sdram_pkg::CMD_READ) begin
            state_d.st = sdram_pkg::C_RD;
          end
        end
      end
      sdram_pkg::C_WR: begin
        if (state_q.phase == P_DQS_HI) begin
          state_d.dqs_o = '1;
        end else if (state_q.phase == P_LAST) begin
          state_d.dq_o = state_q.wbuf[2*DQ_W-1:DQ_W];
          state_d.dm = state_q.wmask[2*LANES-1:LANES];
        end else if (state_q.phase == P_DQS_LO) begin
          state_d.dqs_o = '0;
        end else if (state_q.phase == P_CMD) begin
          state_d.dq_oe = 1'b0;
          state_d.dqs_oe = 1'b0;
          state_d.dm = '0;
          state_d.st = sdram_pkg::C_IDLE;
        end
      end
      sdram_pkg::C_RD: begin
        for (int l = 0; l < LANES; l++) begin
          if (state_q.s2.dqs[l] && !state_q.dqs_prev[l]) begin
            state_d.rdata[l*8 +: 8] = state_q.s2.dq[l*8 +: 8];
          end
          if (!state_q.s2.dqs[l] && state_q.dqs_prev[l]) begin
            state_d.rdata[DQ_W + l*8 +: 8] = state_q.s2.dq[l*8 +: 8];
          end
        end
        if (!state_q.s2.dqs[0] && state_q.dqs_prev[0]) begin
          state_d.rvalid = 1'b1;
          state_d.st = sdram_pkg::C_IDLE;
        end else if (state_q.phase == P_CMD) begin
          state_d.wait_cnt = state_q.wait_cnt + 2'h1;
          if (state_q.wait_cnt == `RD_WAIT_PERIODS - 2'h1) begin
            state_d.st = sdram_pkg::C_IDLE;
          end
        end
      end
      default: begin
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state_q <= '0;
      // last phase with clock low, so the first high half is a full one
      state_q.phase <= P_LAST;
      state_q.cs_n <= 1'b1;
      state_q.ras_n <= 1'b1;
      state_q.cas_n <= 1'b1;
      state_q.we_n <= 1'b1;
    end else begin
      state_q <= state_d;
    end
  end

  assign link.ck = state_q.ck;
  assign link.cs_n = state_q.cs_n;
  assign link.ras_n = state_q.ras_n;
  assign link.cas_n = state_q.cas_n;
  assign link.we_n = state_q.we_n;
  assign link.bank_select_lsb = state_q.ba[0];
  assign link.bank_select_msb = state_q.ba[1];
  assign link.addr = state_q.addr;
  assign link.dm = state_q.dm;
  assign link.ctl_dq_o = state_q.dq_o;
  assign link.ctl_dq_oe = state_q.dq_oe;
  assign link.ctl_dqs_o = state_q.dqs_o;
  assign link.ctl_dqs_oe = state_q.dqs_oe;
  assign rsp_data = state_q.rdata;
  assign rsp_valid = state_q.rvalid;
  assign temp_alarm = state_q.alarm;
endmodule : sdram_ctl

// ### verilog/sdram_dev.sv
// Purpose: memory device end: command decode, bank state, burst-of-two data, temp flag
// Assumes: link pins come from another domain and are synchronised here
// Notes: small internal array stands in for the cell array
// Function
// - bank select picks bank of ACT/RD/WR/PRE
// - bank select picks mode register on load
// - row on activate, column on read/write
// - address bit 10 requests auto precharge
// - precharge one bank, or all if bit10
// - load takes op-code from address pins
// - data width 16 or 32, range follows
// - device drives strobe on reads, controller writes
// - read strobe edge-aligned, write strobe centred
// - temperature flag high above 85 degrees
// - command inputs sampled on rising link clock, write data on strobe edges
// - chip select high masks every command
// - mask high drops that write byte
`timescale 1ns/1ps
`include "sdram_link_cfg.svh"
module sdram_dev #(
  parameter int DQ_W = 16,
  parameter int ROW_BITS = 2,
  parameter int COL_BITS = 4
) (
  // system
  input wire logic clk,
  input wire logic reset_n,
  // link
  sdram_link_if.dev link,
  // user side
  input wire logic signed [7:0] junction_temp_c,
  output logic [`ADDR_W-1:0] mode_std,
  output logic [`ADDR_W-1:0] mode_ext,
  output logic [`BANKS-1:0] bank_open
);
  localparam int LANES = DQ_W / 8;
  localparam int COL_USE = (DQ_W == 32) ? COL_BITS - 1 : COL_BITS;
  localparam int MAW = 2 + ROW_BITS + COL_USE;
  localparam int DEPTH = 1 << MAW;

  typedef struct packed {
    logic ck;
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic [1:0] ba;
    logic [`ADDR_W-1:0] addr;
    logic [LANES-1:0] dm;
    logic [DQ_W-1:0] dq;
    logic [LANES-1:0] dqs;
  } pins_t;

  typedef struct packed {
    pins_t s1;
    pins_t s2;
    logic ck_prev;
    logic [LANES-1:0] dqs_prev;
    logic [`BANKS-1:0] open;
    logic [`BANKS-1:0][ROW_BITS-1:0] row;
    logic [`BANKS-1:0][`ADDR_W-1:0] mode;
    sdram_pkg::dev_state_t st;
    logic [1:0] bank;
    logic [COL_USE-1:0] col;
    logic ap;
    logic wr_rise;
    logic [DQ_W-1:0] dq_o;
    logic dq_oe;
    logic [LANES-1:0] dqs_o;
    logic dqs_oe;
    logic flag;
  } state_t;

  state_t state_q;
  state_t state_d;
  pins_t pins_in;
  logic [DQ_W-1:0] mem [DEPTH];
  logic [LANES-1:0] wr_en;
  logic [MAW-1:0] wr_addr;
  logic [MAW-1:0] rd_addr;
  logic [DQ_W-1:0] rd_word;
  logic ck_rise;
  logic ck_fall;
  logic cmd_hit;
  logic wr_beat;
  logic [LANES-1:0] dqs_rise;
  logic [LANES-1:0] dqs_fall;
  sdram_pkg::cmd_t cmd;

  // array location of one beat of the open row
  function automatic logic [MAW-1:0] loc(
    input logic [1:0] b,
    input logic [ROW_BITS-1:0] r,
    input logic [COL_USE-1:0] c,
    input logic beat
  );
    return {b, r, c[COL_USE-1:1], beat};
  endfunction : loc

  assign pins_in = {link.ck, link.cs_n, link.ras_n, link.cas_n, link.we_n,
                    link.bank_select_msb, link.bank_select_lsb, link.addr,
                    link.dm, link.dq, link.dqs};
  assign ck_rise = state_q.s2.ck & ~state_q.ck_prev;
  assign ck_fall = ~state_q.s2.ck & state_q.ck_prev;
  assign cmd_hit = ck_rise & ~state_q.s2.cs_n;
  assign cmd = sdram_pkg::cmd_t'({state_q.s2.ras_n, state_q.s2.cas_n, state_q.s2.we_n});
  assign dqs_rise = state_q.s2.dqs & ~state_q.dqs_prev;
  assign dqs_fall = ~state_q.s2.dqs & state_q.dqs_prev;
  assign wr_beat = |dqs_fall;
  assign wr_addr = loc(state_q.bank, state_q.row[state_q.bank], state_q.col, wr_beat);
  assign rd_addr = loc(state_q.bank, state_q.row[state_q.bank], state_q.col,
                       state_q.st == sdram_pkg::D_RD_B1);
  assign rd_word = mem[rd_addr];

  always_comb begin
    state_d = state_q;
    wr_en = '0;
    state_d.s1 = pins_in;
    state_d.s2 = state_q.s1;
    state_d.ck_prev = state_q.s2.ck;
    state_d.dqs_prev = state_q.s2.dqs;
    state_d.flag = junction_temp_c > `TEMP_LIMIT_C;
    case (state_q.st)
      sdram_pkg::D_RD_PRE: begin
        if (ck_fall) begin
          state_d.dq_oe = 1'b1;
          state_d.dqs_oe = 1'b1;
          state_d.dqs_o = '0;
          state_d.st = sdram_pkg::D_RD_B0;
        end
      end
      sdram_pkg::D_RD_B0: begin
        if (ck_rise) begin
          state_d.dq_o = rd_word;
          state_d.dqs_o = '1;
          state_d.st = sdram_pkg::D_RD_B1;
        end
      end
      sdram_pkg::D_RD_B1: begin
        if (ck_fall) begin
          state_d.dq_o = rd_word;
          state_d.dqs_o = '0;
          state_d.st = sdram_pkg::D_RD_END;
        end
      end
      sdram_pkg::D_RD_END: begin
        if (ck_rise) begin
          state_d.dq_oe = 1'b0;
          state_d.dqs_oe = 1'b0;
          state_d.st = sdram_pkg::D_IDLE;
          if (state_q.ap) begin
            state_d.open[state_q.bank] = 1'b0;
          end
        end
      end
      sdram_pkg::D_WR: begin
        for (int l = 0; l < LANES; l++) begin
          // each lane captured on its own strobe edges
          wr_en[l] = (dqs_rise[l] | dqs_fall[l]) & ~state_q.s2.dm[l];
        end
        if (ck_rise) begin
          state_d.wr_rise = 1'b1;
        end
        if (wr_beat || (ck_rise && state_q.wr_rise)) begin
          state_d.st = sdram_pkg::D_IDLE;
          if (state_q.ap) begin
            state_d.open[state_q.bank] = 1'b0;
          end
        end
      end
      default: begin
      end
    endcase
    if (cmd_hit) begin
      case (cmd)
        sdram_pkg::CMD_ACT: begin
          state_d.open[state_q.s2.ba] = 1'b1;
          state_d.row[state_q.s2.ba] = state_q.s2.addr[ROW_BITS-1:0];
        end
        sdram_pkg::CMD_READ, sdram_pkg::CMD_WRITE: begin
          if (state_q.st == sdram_pkg::D_IDLE && state_q.open[state_q.s2.ba]) begin
            state_d.bank = state_q.s2.ba;
            state_d.col = state_q.s2.addr[COL_USE-1:0];
            state_d.ap = state_q.s2.addr[`AUTO_PRE_BIT];
            state_d.wr_rise = 1'b0;
            state_d.st = (cmd == sdram_pkg::CMD_READ) ? sdram_pkg::D_RD_PRE : sdram_pkg::D_WR;
          end
        end
        sdram_pkg::CMD_PRE: begin
          if (state_q.s2.addr[`AUTO_PRE_BIT]) begin
            state_d.open = '0;
          end else begin
            state_d.open[state_q.s2.ba] = 1'b0;
          end
        end
        sdram_pkg::CMD_LMR: begin
          state_d.mode[state_q.s2.ba] = state_q.s2.addr;
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    for (int l = 0; l < LANES; l++) begin
      if (wr_en[l]) begin
        mem[wr_addr][l*8 +: 8] <= state_q.s2.dq[l*8 +: 8];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state_q <= '0;
      state_q.s1.cs_n <= 1'b1;
      state_q.s2.cs_n <= 1'b1;
      state_q.s1.ck <= 1'b1;
      state_q.s2.ck <= 1'b1;
      state_q.ck_prev <= 1'b1;
    end else begin
      state_q <= state_d;
    end
  end

  assign link.dev_dq_o = state_q.dq_o;
  assign link.dev_dq_oe = state_q.dq_oe;
  assign link.dev_dqs_o = state_q.dqs_o;
  assign link.dev_dqs_oe = state_q.dqs_oe;
  assign link.over_temperature_flag = state_q.flag;
  assign mode_std = state_q.mode[0];
  assign mode_ext = state_q.mode[2];
  assign bank_open = state_q.open;
endmodule : sdram_dev
